// ### shared/tsi_defines.svh
// Constants for the time-slot interchange switch: timing, map and fields.
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TSI_CLK_HZ 50000000
`define TSI_FRAME_HZ 8000
`define TSI_BIT_HZ 2048000
// A frame is a longest time, so it rounds down to whole cycles.
`define TSI_FRAME_CYC (`TSI_CLK_HZ / `TSI_FRAME_HZ)
// A bit cell also rounds down; the frame keeps the spare cycles idle.
`define TSI_BIT_CYC (`TSI_CLK_HZ / `TSI_BIT_HZ)
`define TSI_BITS_PER_FRAME 8'hff
`define TSI_LAST_BIT 3'h7
`define TSI_FIRST_BIT 3'h0

// ----------------------------------------------------------------------
// Channels and memories
// ----------------------------------------------------------------------
`define TSI_NCHAN 384
`define TSI_NSTREAM 12
`define TSI_BUS_STREAMS 8
`define TSI_LOC_STREAMS 4
`define TSI_LAST_STREAM 4'hb
`define TSI_FIFO_DEPTH 32

// Connection memory entry fields.
`define TSI_CM_ADDR_MSB 8
`define TSI_CM_PAIR_DIR 9
`define TSI_CM_MSG 10
`define TSI_CM_EN 11

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define TSI_DM_BASE 16'h0000
`define TSI_CML_BASE 16'h0800
`define TSI_CMH_BASE 16'h1000
`define TSI_AREA_SIZE 16'h0600
`define TSI_CTRL_ADDR 16'h2000
`define TSI_STAT_ADDR 16'h2004
`define TSI_CTRL_RST 1'h1
`define TSI_CTRL_EN_BIT 0
`define TSI_STAT_OVR_BIT 0
`define TSI_RESP_OKAY 2'h0
`define TSI_RESP_SLVERR 2'h2

`endif

// ### shared/tsi_pkg.sv
// Types shared by the time-slot interchange switch.
package tsi_pkg;

   // Write side of the register bus.
   typedef enum logic [2:0] {
      TSI_W_IDLE = 3'h1,
      TSI_W_EXEC = 3'h2,
      TSI_W_RESP = 3'h4
   } tsi_wr_e;

   // Register bus decode targets.
   typedef enum logic [5:0] {
      TSI_A_DM = 6'h01,
      TSI_A_CML = 6'h02,
      TSI_A_CMH = 6'h04,
      TSI_A_CTRL = 6'h08,
      TSI_A_STAT = 6'h10,
      TSI_A_NONE = 6'h20
   } tsi_area_e;

   typedef logic [11:0] tsi_cm_t;
   typedef logic [7:0] tsi_dm_t;

endpackage : tsi_pkg

// ### src/tsi_switch.sv
// Time-slot interchange switch with its sample FIFO and register slave.
`timescale 1ns/100ps
`include "tsi_defines.svh"

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module tsi_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
   logic [AW:0] wptr_q;            // Write pointer with wrap bit.
   logic [AW:0] rptr_q;            // Read pointer with wrap bit.

   // Full when the pointers differ only in the wrap bit.
   assign in_ready = !((wptr_q[AW] != rptr_q[AW]) &&
                       (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
   assign out_valid = (wptr_q != rptr_q);
   assign out_data = mem[rptr_q[AW-1:0]];

   // Write port.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wptr_q <= '0;
      end else if (in_valid && in_ready) begin
         mem[wptr_q[AW-1:0]] <= in_data;
         wptr_q <= wptr_q + 1'b1;
      end
   end

   // Read port.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rptr_q <= '0;
      end else if (out_valid && out_ready) begin
         rptr_q <= rptr_q + 1'b1;
      end
   end
endmodule : tsi_fifo

module tsi_switch #(
   parameter int FRAME_CYC = `TSI_FRAME_CYC,
   parameter int BIT_CYC = `TSI_BIT_CYC,
   parameter int FIFO_DEPTH = `TSI_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // AXI4-Lite write address and data.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response.
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read.
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [15:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Backplane inbound streams, two-way.
   input wire logic [7:0] bus_inbound_streams_i,
   output logic [7:0] bus_inbound_streams_o,
   output logic [7:0] bus_inbound_streams_oe,
   // Backplane outbound streams, two-way.
   input wire logic [7:0] bus_outbound_streams_i,
   output logic [7:0] bus_outbound_streams_o,
   output logic [7:0] bus_outbound_streams_oe,
   // Local serial streams and per-channel local controls.
   input wire logic [3:0] local_in,
   output logic [3:0] local_out,
   output logic [3:0] control_output_stream,
   output logic [3:0] local_dma_enable
);
   localparam int NS = `TSI_NSTREAM;

   // ----------------------------------------------------------------------
   // Memories and shared state
   // ----------------------------------------------------------------------
   tsi_pkg::tsi_dm_t dm [`TSI_NCHAN];   // Data memory.
   tsi_pkg::tsi_cm_t cm [`TSI_NCHAN];   // Connection memory.
   logic [7:0] cm_low_tmp_q;            // Pending connection low bits.
   logic sw_en_q;                       // Switching enable from software.
   logic ovr_q;                         // Sticky sample overrun.
   logic [12:0] cyc_q;                  // Position in the frame.
   logic [12:0] bdiv_q;                 // Position in the bit cell.
   logic [7:0] bit_idx_q;               // Bit cell number in the frame.
   logic active_q;                      // Bit cells still running.
   logic bit_en;                        // One-cycle end-of-cell pulse.
   logic [4:0] ch;                      // Channel on the wire.
   logic [19:0] rx_s1_q;                // First synchroniser stage.
   logic [19:0] rx_s2_q;                // Second synchroniser stage.
   logic [7:0] in_sh_q [NS];            // Input shift registers.
   logic [7:0] in_lat_q [NS];           // Input holding latches.
   logic [4:0] lat_ch_q;                // Channel held in the latches.
   logic wseq_busy_q;                   // Latches being queued.
   logic [3:0] wseq_s_q;                // Stream being queued.
   logic rseq_busy_q;                   // Holding registers filling.
   logic [3:0] rseq_s_q;                // Stream being filled.
   logic [7:0] out_hold_q [NS];         // Output holding registers.
   logic [2:0] hold_ctl_q [NS];         // Control bits for next channel.
   logic [7:0] out_sh_q [NS];           // Output shift registers.
   logic [2:0] cur_ctl_q [NS];          // Control bits on the wire.
   logic [NS-1:0] rx_bit;               // Received bit per stream.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [16:0] fifo_out_data;
   logic cpu_dm_we;                     // Processor writes data memory.
   logic cpu_cmh_we;                    // Processor commits an entry.
   logic [15:0] waddr_q; // Write address as taken.
   logic [7:0] wdat_q; // Write data as taken.
   logic wstb_q; // Low byte strobe as taken.
   logic wr_go;
   tsi_pkg::tsi_cm_t rd_entry;          // Entry for the stream filling.
   logic [8:0] rd_idx;                  // Its connection index.

   // ----------------------------------------------------------------------
   // Frame counter and bit cells
   // ----------------------------------------------------------------------
   assign bit_en = active_q && (bdiv_q == 13'(BIT_CYC - 1));
   assign ch = bit_idx_q[7:3];

   // The frame restarts every frame period; spare cycles stay idle.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cyc_q <= '0;
         bdiv_q <= '0;
         bit_idx_q <= '0;
         active_q <= 1'b1;
      end else if (cyc_q == 13'(FRAME_CYC - 1)) begin
         cyc_q <= '0;
         bdiv_q <= '0;
         bit_idx_q <= '0;
         active_q <= 1'b1;
      end else begin
         cyc_q <= cyc_q + 1'b1;
         if (bit_en) begin
            bdiv_q <= '0;
            bit_idx_q <= bit_idx_q + 1'b1;
            active_q <= (bit_idx_q != `TSI_BITS_PER_FRAME);
         end else if (active_q) begin
            bdiv_q <= bdiv_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers and receive selection
   // ----------------------------------------------------------------------
   // Only the second stage is read anywhere.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_s1_q <= '0;
         rx_s2_q <= '0;
      end else begin
         rx_s1_q <= {local_in, bus_outbound_streams_i, bus_inbound_streams_i};
         rx_s2_q <= rx_s1_q;
      end
   end

   // A pair receives on whichever member it does not drive.
   always_comb begin
      for (int s = 0; s < `TSI_BUS_STREAMS; s++) begin
         rx_bit[s] = cur_ctl_q[s][1] ? rx_s2_q[s] : rx_s2_q[s + 8];
      end
      for (int l = 0; l < `TSI_LOC_STREAMS; l++) begin
         rx_bit[l + 8] = rx_s2_q[l + 16];
      end
   end

   // ----------------------------------------------------------------------
   // Serial to parallel
   // ----------------------------------------------------------------------
   // Bits arrive first to last; the latch frees the shifter for the next
   // channel while the queue walks the twelve latches.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int s = 0; s < NS; s++) begin
            in_sh_q[s] <= '0;
            in_lat_q[s] <= '0;
         end
         lat_ch_q <= '0;
      end else if (bit_en) begin
         for (int s = 0; s < NS; s++) begin
            in_sh_q[s] <= {in_sh_q[s][6:0], rx_bit[s]};
            if (bit_idx_q[2:0] == `TSI_LAST_BIT) begin
               in_lat_q[s] <= {in_sh_q[s][6:0], rx_bit[s]};
            end
         end
         if (bit_idx_q[2:0] == `TSI_LAST_BIT) begin
            lat_ch_q <= ch;
         end
      end
   end

   // Queue latched samples, one stream a cycle, in a fixed order.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wseq_busy_q <= 1'b0;
         wseq_s_q <= '0;
      end else if (bit_en && (bit_idx_q[2:0] == `TSI_LAST_BIT) && sw_en_q) begin
         wseq_busy_q <= 1'b1;
         wseq_s_q <= '0;
      end else if (wseq_busy_q) begin
         wseq_busy_q <= (wseq_s_q != `TSI_LAST_STREAM);
         wseq_s_q <= wseq_s_q + 1'b1;
      end
   end

   // Stream and channel concatenate into a unique location: backplane
   // streams fill 0 to 255 and local streams 256 to 383.
   tsi_fifo #(
      .WIDTH(17),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(wseq_busy_q),
      .in_ready(fifo_in_ready),
      .in_data({wseq_s_q, lat_ch_q, in_lat_q[wseq_s_q]}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // The processor takes the data memory port first; the queue waits.
   assign fifo_out_ready = !cpu_dm_we;

   // Data memory writes: cleared at reset, then samples and processor.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `TSI_NCHAN; i++) begin
            dm[i] <= '0;
         end
      end else if (cpu_dm_we) begin
         dm[waddr_q[10:2]] <= wdat_q;
      end else if (fifo_out_valid) begin
         dm[fifo_out_data[16:8]] <= fifo_out_data[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Parallel to serial
   // ----------------------------------------------------------------------
   // Prepare the next channel once the first bit of this one is out.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rseq_busy_q <= 1'b0;
         rseq_s_q <= '0;
      end else if (bit_en && (bit_idx_q[2:0] == `TSI_FIRST_BIT)) begin
         rseq_busy_q <= 1'b1;
         rseq_s_q <= '0;
      end else if (rseq_busy_q) begin
         rseq_busy_q <= (rseq_s_q != `TSI_LAST_STREAM);
         rseq_s_q <= rseq_s_q + 1'b1;
      end
   end

   assign rd_idx = {rseq_s_q, 5'(ch + 1'b1)};
   assign rd_entry = cm[rd_idx];

   // Message mode sends the low byte; otherwise the entry addresses the
   // sample, and any number of entries may name the same one.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int s = 0; s < NS; s++) begin
            out_hold_q[s] <= '0;
            hold_ctl_q[s] <= '0;
         end
      end else if (rseq_busy_q) begin
         if (rd_entry[`TSI_CM_MSG]) begin
            out_hold_q[rseq_s_q] <= rd_entry[7:0];
         end else begin
            out_hold_q[rseq_s_q] <= dm[rd_entry[8:0]];
         end
         hold_ctl_q[rseq_s_q] <= rd_entry[11:9];
      end
   end

   // Shift out first to last; the shift register reloads from the holding
   // register at the cell that closes each channel.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int s = 0; s < NS; s++) begin
            out_sh_q[s] <= '0;
            cur_ctl_q[s] <= '0;
         end
      end else if (bit_en) begin
         for (int s = 0; s < NS; s++) begin
            if (bit_idx_q[2:0] == `TSI_LAST_BIT) begin
               out_sh_q[s] <= out_hold_q[s];
               cur_ctl_q[s] <= hold_ctl_q[s];
            end else begin
               out_sh_q[s] <= {out_sh_q[s][6:0], 1'b0};
            end
         end
      end
   end

   // Pin drivers: each backplane pair drives at most one member, none while disabled.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_inbound_streams_o <= '0;
         bus_inbound_streams_oe <= '0;
         bus_outbound_streams_o <= '0;
         bus_outbound_streams_oe <= '0;
      end else begin
         for (int s = 0; s < `TSI_BUS_STREAMS; s++) begin
            bus_outbound_streams_o[s] <= out_sh_q[s][7];
            bus_inbound_streams_o[s] <= out_sh_q[s][7];
            bus_outbound_streams_oe[s] <= sw_en_q && cur_ctl_q[s][2] &&
               cur_ctl_q[s][1];
            bus_inbound_streams_oe[s] <= sw_en_q && cur_ctl_q[s][2] &&
               !cur_ctl_q[s][1];
         end
      end
   end

   // Local streams always drive; their control bits go out per channel.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         local_out <= '0;
         control_output_stream <= '0;
         local_dma_enable <= '0;
      end else begin
         for (int l = 0; l < `TSI_LOC_STREAMS; l++) begin
            local_out[l] <= out_sh_q[l + 8][7];
            control_output_stream[l] <= cur_ctl_q[l + 8][0];
            local_dma_enable[l] <= sw_en_q && cur_ctl_q[l + 8][2];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------------
   tsi_pkg::tsi_wr_e wst_q;
   logic aw_got_q;
   logic w_got_q;
   tsi_pkg::tsi_area_e w_area;
   tsi_pkg::tsi_area_e r_area;

   // Address decode shared by both directions.
   function automatic tsi_pkg::tsi_area_e decode(input logic [15:0] a);
      if (a < `TSI_DM_BASE + `TSI_AREA_SIZE) begin
         decode = tsi_pkg::TSI_A_DM;
      end else if (a >= `TSI_CML_BASE && a < `TSI_CML_BASE + `TSI_AREA_SIZE) begin
         decode = tsi_pkg::TSI_A_CML;
      end else if (a >= `TSI_CMH_BASE && a < `TSI_CMH_BASE + `TSI_AREA_SIZE) begin
         decode = tsi_pkg::TSI_A_CMH;
      end else if (a == `TSI_CTRL_ADDR) begin
         decode = tsi_pkg::TSI_A_CTRL;
      end else if (a == `TSI_STAT_ADDR) begin
         decode = tsi_pkg::TSI_A_STAT;
      end else begin
         decode = tsi_pkg::TSI_A_NONE;
      end
   endfunction : decode

   assign w_area = decode(waddr_q);
   assign r_area = decode(s_axi_araddr);
   assign s_axi_awready = (wst_q == tsi_pkg::TSI_W_IDLE) && !aw_got_q;
   assign s_axi_wready = (wst_q == tsi_pkg::TSI_W_IDLE) && !w_got_q;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = (wst_q == tsi_pkg::TSI_W_EXEC) && wstb_q;
   assign cpu_dm_we = wr_go && (w_area == tsi_pkg::TSI_A_DM);
   assign cpu_cmh_we = wr_go && (w_area == tsi_pkg::TSI_A_CMH);

   // The master may move address and data once taken, so keep copies.
   always_ff @(posedge sys_clk) begin
      if (s_axi_awvalid && s_axi_awready) begin
         waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdat_q <= s_axi_wdata[7:0];
         wstb_q <= s_axi_wstrb[0];
      end
   end

   // Write sequencing: take address and data in either order.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wst_q <= tsi_pkg::TSI_W_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TSI_RESP_OKAY;
      end else begin
         case (wst_q)
            tsi_pkg::TSI_W_IDLE: begin
               if ((aw_got_q || s_axi_awvalid) && (w_got_q || s_axi_wvalid)) begin
                  wst_q <= tsi_pkg::TSI_W_EXEC;
               end
               aw_got_q <= aw_got_q || s_axi_awvalid;
               w_got_q <= w_got_q || s_axi_wvalid;
            end
            tsi_pkg::TSI_W_EXEC: begin
               wst_q <= tsi_pkg::TSI_W_RESP;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp <= (w_area == tsi_pkg::TSI_A_NONE) ?
                              `TSI_RESP_SLVERR : `TSI_RESP_OKAY;
            end
            tsi_pkg::TSI_W_RESP: begin
               if (s_axi_bready) begin
                  wst_q <= tsi_pkg::TSI_W_IDLE;
                  s_axi_bvalid <= 1'b0;
                  aw_got_q <= 1'b0;
                  w_got_q <= 1'b0;
               end
            end
            default: begin
               wst_q <= tsi_pkg::TSI_W_IDLE;
            end
         endcase
      end
   end

   // Connection memory: low bits wait; the high write commits all 12.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cm_low_tmp_q <= '0;
         for (int i = 0; i < `TSI_NCHAN; i++) begin
            cm[i] <= '0;
         end
      end else if (cpu_cmh_we) begin
         cm[waddr_q[10:2]] <= {wdat_q[3:0], cm_low_tmp_q};
      end else if (wr_go && (w_area == tsi_pkg::TSI_A_CML)) begin
         cm_low_tmp_q <= wdat_q;
      end
   end

   // Control and sticky overrun; a new overrun beats the clear.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sw_en_q <= `TSI_CTRL_RST;
         ovr_q <= 1'b0;
      end else begin
         if (wr_go && (w_area == tsi_pkg::TSI_A_CTRL)) begin
            sw_en_q <= wdat_q[`TSI_CTRL_EN_BIT];
         end
         if (wseq_busy_q && !fifo_in_ready) begin
            ovr_q <= 1'b1;
         end else if (wr_go && (w_area == tsi_pkg::TSI_A_STAT) &&
                      wdat_q[`TSI_STAT_OVR_BIT]) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // Reads answer one cycle after the address is taken.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `TSI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TSI_RESP_OKAY;
         case (r_area)
            tsi_pkg::TSI_A_DM: s_axi_rdata <= {24'h0, dm[s_axi_araddr[10:2]]};
            tsi_pkg::TSI_A_CML: s_axi_rdata <= {24'h0, cm[s_axi_araddr[10:2]][7:0]};
            tsi_pkg::TSI_A_CMH: s_axi_rdata <= {28'h0, cm[s_axi_araddr[10:2]][11:8]};
            tsi_pkg::TSI_A_CTRL: s_axi_rdata <= {31'h0, sw_en_q};
            tsi_pkg::TSI_A_STAT: s_axi_rdata <= {16'h0, bit_idx_q, 7'h0, ovr_q};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `TSI_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : tsi_switch

// ### testbench/tsi_switch_sva.sv
// Checker of the switch's bus handshakes and serial pins.
`timescale 1ns/100ps
module tsi_switch_chk (
   input wire logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready,
   input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0] bus_inbound_streams_oe, bus_outbound_streams_oe,
   input wire logic [3:0] local_out, local_dma_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("bvalid late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("rvalid late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready while busy");
   a_write_refuse: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("awready while busy");
   a_pair_exclusive: assert property ((bus_inbound_streams_oe &
      bus_outbound_streams_oe) == 8'h00) else $error("both pair pins driven");
   a_serial_steady: assert property ($changed(local_out)
      |=> $stable(local_out)[*3]) else $error("bit cell too short");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
      !s_axi_bvalid && !s_axi_rvalid && local_out == 4'h0 &&
      local_dma_enable == 4'h0) else $error("outputs live in reset");
   c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
   c_serial: cover property ($rose(local_out[0]));
endmodule : tsi_switch_chk
bind tsi_switch tsi_switch_chk i_tsi_switch_chk (.*);

// ### testbench/tsi_far_model.sv
// Far-side model: serial sources on the local and backplane pins.
`timescale 1ns/100ps
module tsi_far_model #(parameter int BIT_CYC = 4, FRAME_CYC = 1040,
   parameter logic [7:0] PAT = 8'h5a) (
   input wire logic sys_clk, sys_rst,
   input wire logic [7:0] in_o, in_oe, out_o, out_oe,
   output logic [7:0] in_i, out_i,
   output logic [3:0] local_in
);
   int fc; // Frame cycle, aligned with the switch's free-running frame.
   logic bit_q;
   always_ff @(posedge sys_clk) fc <= (sys_rst || fc == FRAME_CYC-1) ? 0 : fc+1;
   // MSB first; the spare idle cycles carry a toggling filler.
   assign bit_q = fc < 256*BIT_CYC ? PAT[7-((fc/BIT_CYC)%8)] : fc[0];
   assign local_in = {4{bit_q}};
   // A pin the switch drives shows its value, else this side drives it.
   assign in_i = (in_oe & in_o) | (~in_oe & {8{bit_q}});
   assign out_i = (out_oe & out_o) | (~out_oe & {8{bit_q}});
endmodule : tsi_far_model

// ### testbench/testbench.sv
// Self-checking bench of the time-slot switch.
`timescale 1ns/100ps
`include "tsi_defines.svh"
module testbench;
   localparam int BC = 4, FC = 1040;
   localparam logic [7:0] PAT = 8'h5a;
   localparam logic [3:0] MSG = 4'b1001; // Which test channels send a message.
   logic sys_clk = 0, sys_rst = 1, awv = 0, wv = 0, arv = 0, rr = 0;
   logic awr, wrd, bv, arr, rv;
   logic [1:0] br, rrsp;
   logic [31:0] rd, wd = 0, seed = 97;
   logic [15:0] awa = 0, ara = 0;
   logic [7:0] ii, io, ioe, oi, oo, ooe, cap [32];
   logic [3:0] li, lo, lde;
   logic dmc [33]; // DMA enable seen in each channel of stream 8.
   int fc = 0, cyc = 0, error_cnt = 0, checks = 0;
   tsi_switch #(.FRAME_CYC(FC), .BIT_CYC(BC)) i_tsi_switch (.sys_clk, .sys_rst,
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
      .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .s_axi_rdata(rd), .s_axi_rresp(rrsp), .bus_inbound_streams_i(ii),
      .bus_inbound_streams_o(io), .bus_inbound_streams_oe(ioe),
      .bus_outbound_streams_i(oi), .bus_outbound_streams_o(oo),
      .bus_outbound_streams_oe(ooe), .local_in(li), .local_out(lo),
      .control_output_stream(), .local_dma_enable(lde));
   tsi_far_model #(.BIT_CYC(BC), .FRAME_CYC(FC), .PAT(PAT)) i_tsi_far_model (
      .sys_clk, .sys_rst, .in_o(io), .in_oe(ioe), .out_o(oo), .out_oe(ooe),
      .in_i(ii), .out_i(oi), .local_in(li));
   initial forever #10 sys_clk = ~sys_clk;
   // Frame counter, capture of each channel's byte on stream 8, watchdog.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      fc <= (sys_rst || fc == FC-1) ? 0 : fc + 1;
      if (fc % BC == 2 && fc < 256*BC) cap[fc/(8*BC)] <= {cap[fc/(8*BC)][6:0], lo[0]};
      if (fc % BC == 2) dmc[fc/(8*BC)] <= lde[0];
      if (cyc == 40000) begin
         error_cnt++;
         print_verdict;
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [15:0] ad(input logic [15:0] b, input int i);
      return b + 16'(i*4);
   endfunction : ad
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Write, then wait for the response.
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta, tw;
      ta = 0;
      tw = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      while (!(ta && tw)) begin
         @(posedge sys_clk);
         if (awr && !ta) begin ta = 1; awv <= 0; end
         if (wrd && !tw) begin tw = 1; wv <= 0; end
      end
      do @(posedge sys_clk); while (!bv);
      chk(32'(br), 32'(e));
   endtask : wr
   // Read; rready is raised at a random moment after the address.
   task automatic rdt(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
      ara <= a;
      arv <= 1;
      do @(posedge sys_clk); while (!arr);
      arv <= 0;
      void'(xs());
      if (seed[0]) @(posedge sys_clk);
      rr <= 1;
      do @(posedge sys_clk); while (!rv);
      rr <= 0;
      chk(rd, d);
      chk(32'(rrsp), 32'(e));
   endtask : rdt
   initial begin
      logic [7:0] b [4];
      repeat (4) @(posedge sys_clk);
      sys_rst <= 0;
      rdt(`TSI_CTRL_ADDR, 32'h1, `TSI_RESP_OKAY);
      rdt(ad(`TSI_CMH_BASE, 261), 32'h0, `TSI_RESP_OKAY);
      wr(16'h3000, 32'h0, `TSI_RESP_SLVERR);
      rdt(16'h3000, 32'h0, `TSI_RESP_SLVERR);
      $display("test map done");
      // Stream 8 channels 4..7: messages, and two listeners of one source.
      for (int k = 0; k < 4; k++) begin
         b[k] = MSG[k] ? 8'(xs()) : 8'h23;
         wr(ad(`TSI_CML_BASE, 260+k), 32'(b[k]), `TSI_RESP_OKAY);
         rdt(ad(`TSI_CML_BASE, 260+k), 32'h0, `TSI_RESP_OKAY);
         wr(ad(`TSI_CMH_BASE, 260+k), MSG[k] ? 32'hc : 32'h1, `TSI_RESP_OKAY);
         rdt(ad(`TSI_CML_BASE, 260+k), 32'(b[k]), `TSI_RESP_OKAY);
         rdt(ad(`TSI_CMH_BASE, 260+k), MSG[k] ? 32'hc : 32'h1, `TSI_RESP_OKAY);
      end
      $display("test connection memory done");
      wr(ad(`TSI_DM_BASE, 291), 32'(~PAT), `TSI_RESP_OKAY);
      repeat (3*FC) @(posedge sys_clk);
      rdt(ad(`TSI_DM_BASE, 291), 32'(PAT), `TSI_RESP_OKAY);
      while (fc != FC-10) @(posedge sys_clk);
      for (int k = 0; k < 4; k++) begin
         chk(32'(cap[4+k]), MSG[k] ? 32'(b[k]) : 32'(PAT));
         chk(32'(dmc[4+k]), 32'(MSG[k]));
      end
      $display("test switching done");
      print_verdict;
   end
   task automatic print_verdict;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
endmodule : testbench
